/* File: verilog/mlt_pkg.sv */
// Constants shared by the message translator: codes, ranges and reset values.
package mlt_pkg;

	// Incoming query function codes.
	localparam logic [7:0] FC_READ_COILS    = 8'h01;
	localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
	localparam logic [7:0] FC_READ_HOLDING  = 8'h03;
	localparam logic [7:0] FC_READ_INPUT    = 8'h04;
	localparam logic [7:0] FC_WRITE_COIL    = 8'h05;
	localparam logic [7:0] FC_WRITE_REG     = 8'h06;
	localparam logic [7:0] FC_WRITE_COILS   = 8'h0F;
	localparam logic [7:0] FC_WRITE_REGS    = 8'h10;

	// Legacy network opcodes.
	localparam logic [7:0] OP_PRIO_READ     = 8'h20;
	localparam logic [7:0] OP_NPRIO_READ    = 8'h00;
	localparam logic [7:0] OP_PRIO_WRITE    = 8'h1E;
	localparam logic [7:0] OP_NPRIO_WRITE   = 8'h02;
	localparam logic [7:0] OP_PRINT         = 8'h22;
	localparam logic [7:0] OP_PRINT_REPLY   = 8'h92;

	// Status word codes; the two coil reads carry their low byte only.
	localparam logic [7:0]  ST_LOW_COILS    = 8'h03;
	localparam logic [7:0]  ST_LOW_DISCRETE = 8'h05;
	localparam logic [15:0] ST_READ_HOLDING = 16'h0006;
	localparam logic [15:0] ST_READ_INPUT   = 16'h0009;
	localparam logic [15:0] ST_WRITE_REG    = 16'h000D;
	localparam logic [15:0] ST_WRITE_COILS  = 16'h001F;
	localparam logic [15:0] ST_WRITE_REGS   = 16'h0020;
	localparam logic [15:0] ST_WRAPPED      = 16'hBAD5;

	// Transaction numbers of the non-priority forms.
	localparam logic [7:0] TN_READ_HOLDING  = 8'h03;
	localparam logic [7:0] TN_WRITE_COIL    = 8'h05;
	localparam logic [7:0] TN_WRITE_REG     = 8'h06;
	localparam logic [7:0] TN_WRITE_COILS   = 8'h0F;
	localparam logic [7:0] TN_WRITE_REGS    = 8'h10;

	// Register ranges; the upper range folds onto the lower one.
	localparam logic [15:0] REG_LOW_FIRST   = 16'h0001;
	localparam logic [15:0] REG_LOW_LAST    = 16'h2000;
	localparam logic [15:0] REG_HIGH_LAST   = 16'h4000;
	localparam logic [15:0] COILS_PER_REG   = 16'h0010;

	// Reset values of the registered outputs.
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam logic [15:0] RST_WORD        = 16'h0000;

endpackage

/* File: verilog/mlt_translator.sv */
// Query translator between the serial register protocol and the legacy network.
module mlt_translator (
	input  wire logic        clock,          // Single 250 MHz clock.
	input  wire logic        rst,            // Synchronous reset, active high.
	input  wire logic        q_valid,        // Pulse: an inbound item is offered.
	input  wire logic        q_reply,        // Item is a reply to a wrapped query.
	input  wire logic [7:0]  q_func,         // Function code of the inbound query.
	input  wire logic [15:0] q_start,        // First register or coil, one based.
	input  wire logic [15:0] q_count,        // Number of registers or coils.
	output logic             l_valid,        // Pulse: a legacy message is ready.
	output logic [7:0]       l_opcode,       // Legacy opcode.
	output logic [15:0]      l_status,       // Status word code.
	output logic             l_status_sel,   // Access targets the status field.
	output logic [7:0]       l_transnum,     // Transaction number, zero if unused.
	output logic [15:0]      l_register,     // Legacy register number.
	output logic [15:0]      l_mask,         // Write mask, zero if unused.
	output logic             l_wrap,         // Message is carried in an envelope.
	output logic [7:0]       l_addr_byte,    // Address byte after the status word.
	input  wire logic        host_mode,      // High: host mode, low: gate mode.
	input  wire logic [7:0]  host_read_fc,   // Configured read function code.
	input  wire logic [7:0]  host_write_fc,  // Configured write function code.
	input  wire logic [15:0] host_bias,      // Configured register bias.
	input  wire logic        m_valid,        // Pulse: an outbound legacy request.
	input  wire logic        m_write,        // Request is a write.
	input  wire logic [7:0]  m_transnum,     // Transaction number of the request.
	input  wire logic [15:0] m_count,        // Register or coil count of the request.
	input  wire logic [15:0] m_remote,       // Legacy remote register number.
	output logic             mb_valid,       // Pulse: an outbound query is ready.
	output logic [7:0]       mb_func,        // Outbound function code.
	output logic [15:0]      mb_register     // Outbound register number.
);

	// All state of the block; every output is a field of it.
	typedef struct packed {
		logic        l_valid;
		logic [7:0]  l_opcode;
		logic [15:0] l_status;
		logic        l_status_sel;
		logic [7:0]  l_transnum;
		logic [15:0] l_register;
		logic [15:0] l_mask;
		logic        l_wrap;
		logic [7:0]  l_addr_byte;
		logic [15:0] bias;
		logic        mb_valid;
		logic [7:0]  mb_func;
		logic [15:0] mb_register;
	} mlt_state_type;

	mlt_state_type state;       // Registered state.
	mlt_state_type next_state;  // Value for the next edge.

	// Builds a mask of count ones starting at bit; count up to sixteen only.
	function automatic logic [15:0] mlt_mask(input logic [3:0] bit_pos, input logic [4:0] cnt);
		logic [16:0] ones;
		ones = (17'h00001 << cnt) - 17'h00001;
		return ones[15:0] << bit_pos;
	endfunction

	// Tells whether a register number lies in the given one-based range.
	function automatic logic mlt_in(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	// Zero-based coil index, register holding it and bit within that register.
	logic [15:0] coil_idx;
	logic [15:0] coil_reg;
	logic [3:0]  coil_bit;
	logic        in_low;
	logic        in_high;
	logic [15:0] folded;
	logic        last_reg_ok;

	// Shared address arithmetic for the inbound path.
	always_comb begin
		coil_idx = q_start - mlt_pkg::REG_LOW_FIRST;
		coil_reg = (coil_idx >> 4) + mlt_pkg::REG_LOW_FIRST;
		coil_bit = coil_idx[3:0];
		in_low   = mlt_in(q_start, mlt_pkg::REG_LOW_FIRST, mlt_pkg::REG_LOW_LAST);
		in_high  = mlt_in(q_start, mlt_pkg::REG_LOW_LAST + mlt_pkg::REG_LOW_FIRST,
			mlt_pkg::REG_HIGH_LAST);
		folded   = q_start - mlt_pkg::REG_LOW_LAST;
		last_reg_ok = ({1'b0, coil_bit} + q_count[4:0]) <= 5'h10;
	end

	// Next state: translate one inbound item and one outbound request per cycle.
	always_comb begin
		next_state = state;
		next_state.l_valid = 1'b0;
		next_state.mb_valid = 1'b0;
		next_state.bias = host_bias;
		if (q_valid) begin
			next_state.l_valid      = 1'b1;
			next_state.l_status_sel = 1'b0;
			next_state.l_transnum   = mlt_pkg::RST_BYTE;
			next_state.l_register   = q_start;
			next_state.l_mask       = mlt_pkg::RST_WORD;
			next_state.l_wrap       = 1'b0;
			next_state.l_status     = mlt_pkg::RST_WORD;
			next_state.l_opcode     = mlt_pkg::OP_PRINT;
			next_state.l_addr_byte  = mlt_pkg::RST_BYTE;
			// The reply path is decided first: a reply is never re-translated.
			if (q_reply) begin
				next_state.l_opcode = mlt_pkg::OP_PRINT_REPLY;
				next_state.l_status = mlt_pkg::ST_WRAPPED;
				next_state.l_wrap   = 1'b1;
			end else begin
				// Start from the envelope; mapped cases below overwrite it.
				// wrap untranslatable
				next_state.l_status = mlt_pkg::ST_WRAPPED;
				next_state.l_wrap   = 1'b1;
				case (q_func)
					// Coil reads address the register holding the first coil.
					mlt_pkg::FC_READ_COILS: begin
						next_state.l_opcode   = mlt_pkg::OP_PRIO_READ;
						next_state.l_status   = {coil_bit, q_count[3:0],
							mlt_pkg::ST_LOW_COILS};
						next_state.l_register = coil_reg;
						next_state.l_wrap     = 1'b0;
					end
					mlt_pkg::FC_READ_DISCRETE: begin
						next_state.l_opcode   = mlt_pkg::OP_PRIO_READ;
						next_state.l_status   = {coil_bit, q_count[3:0],
							mlt_pkg::ST_LOW_DISCRETE};
						next_state.l_register = coil_reg;
						next_state.l_wrap     = 1'b0;
					end
					mlt_pkg::FC_READ_HOLDING: begin
						if (in_low) begin
							next_state.l_opcode = mlt_pkg::OP_PRIO_READ;
							next_state.l_status = mlt_pkg::ST_READ_HOLDING;
							next_state.l_wrap   = 1'b0;
						end else if (in_high) begin
							next_state.l_opcode     = mlt_pkg::OP_NPRIO_READ;
							next_state.l_status     = mlt_pkg::RST_WORD;
							next_state.l_status_sel = 1'b1;
							next_state.l_transnum   = mlt_pkg::TN_READ_HOLDING;
							next_state.l_register   = folded;
							next_state.l_wrap       = 1'b0;
						end
					end
					mlt_pkg::FC_READ_INPUT: begin
						// Only the lower range has a mapping for input registers.
						if (in_low) begin
							next_state.l_opcode = mlt_pkg::OP_NPRIO_READ;
							next_state.l_status = mlt_pkg::ST_READ_INPUT;
							next_state.l_wrap   = 1'b0;
						end
					end
					mlt_pkg::FC_WRITE_COIL: begin
						next_state.l_opcode   = mlt_pkg::OP_NPRIO_WRITE;
						next_state.l_status   = mlt_pkg::RST_WORD;
						next_state.l_transnum = mlt_pkg::TN_WRITE_COIL;
						next_state.l_mask     = mlt_mask(coil_bit, 5'h01);
						next_state.l_register = coil_reg;
						next_state.l_wrap     = 1'b0;
					end
					mlt_pkg::FC_WRITE_REG: begin
						if (in_low) begin
							next_state.l_opcode = mlt_pkg::OP_PRIO_WRITE;
							next_state.l_status = mlt_pkg::ST_WRITE_REG;
							next_state.l_wrap   = 1'b0;
						end else if (in_high) begin
							next_state.l_opcode     = mlt_pkg::OP_NPRIO_WRITE;
							next_state.l_status     = mlt_pkg::RST_WORD;
							next_state.l_status_sel = 1'b1;
							next_state.l_transnum   = mlt_pkg::TN_WRITE_REG;
							next_state.l_register   = folded;
							next_state.l_wrap       = 1'b0;
						end
					end
					mlt_pkg::FC_WRITE_COILS: begin
						// Whole aligned words take the priority form.
						if (coil_bit == 4'h0 && q_count[3:0] == 4'h0 &&
							q_count != mlt_pkg::RST_WORD) begin
							next_state.l_opcode   = mlt_pkg::OP_PRIO_WRITE;
							next_state.l_status   = mlt_pkg::ST_WRITE_COILS;
							next_state.l_register = coil_reg;
							next_state.l_wrap     = 1'b0;
						end else if (q_count < mlt_pkg::COILS_PER_REG &&
							q_count != mlt_pkg::RST_WORD && last_reg_ok) begin
							next_state.l_opcode   = mlt_pkg::OP_NPRIO_WRITE;
							next_state.l_status   = mlt_pkg::RST_WORD;
							next_state.l_transnum = mlt_pkg::TN_WRITE_COILS;
							next_state.l_mask     = mlt_mask(coil_bit, q_count[4:0]);
							next_state.l_register = coil_reg;
							next_state.l_wrap     = 1'b0;
						end
					end
					mlt_pkg::FC_WRITE_REGS: begin
						if (in_low) begin
							next_state.l_opcode = mlt_pkg::OP_PRIO_WRITE;
							next_state.l_status = mlt_pkg::ST_WRITE_REGS;
							next_state.l_wrap   = 1'b0;
						end else if (in_high) begin
							next_state.l_opcode     = mlt_pkg::OP_NPRIO_WRITE;
							next_state.l_status     = mlt_pkg::RST_WORD;
							next_state.l_status_sel = 1'b1;
							next_state.l_transnum   = mlt_pkg::TN_WRITE_REGS;
							next_state.l_register   = folded;
							next_state.l_wrap       = 1'b0;
						end
					end
					// Anything else stays in the envelope set up above.
					default: begin
						next_state.l_wrap = 1'b1;
					end
				endcase
			end
		end
		// Outbound path toward serial slaves.
		if (m_valid) begin
			next_state.mb_valid = 1'b1;
			if (host_mode) begin
				next_state.mb_func = m_write ? host_write_fc : host_read_fc;
				next_state.mb_register = m_remote + host_bias;
			end else begin
				// Gate mode: host_bias is not added and the fixed mapping applies.
				next_state.mb_register = m_remote;
				if (!m_write) begin
					next_state.mb_func = mlt_pkg::FC_READ_HOLDING;
				end else if (m_transnum == mlt_pkg::TN_WRITE_COILS) begin
					next_state.mb_func = (m_count == 16'h0001) ?
						mlt_pkg::FC_WRITE_COIL : mlt_pkg::FC_WRITE_COILS;
				end else begin
					next_state.mb_func = mlt_pkg::FC_WRITE_REGS;
				end
			end
		end
	end

	// State register; reset clears every output to a quiet value.
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs come straight from the state flip-flops.
	assign l_valid      = state.l_valid;
	assign l_opcode     = state.l_opcode;
	assign l_status     = state.l_status;
	assign l_status_sel = state.l_status_sel;
	assign l_transnum   = state.l_transnum;
	assign l_register   = state.l_register;
	assign l_mask       = state.l_mask;
	assign l_wrap       = state.l_wrap;
	assign l_addr_byte  = state.l_addr_byte;
	assign mb_valid     = state.mb_valid;
	assign mb_func      = state.mb_func;
	assign mb_register  = state.mb_register;

	// Checks on the translation; all share the one clock and reset.
	default clocking mlt_cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_HOLD_UPPER: assert property (q_valid && !q_reply && q_func == mlt_pkg::FC_READ_HOLDING
		&& in_high |=> l_opcode == mlt_pkg::OP_NPRIO_READ && l_status_sel
		&& l_transnum == mlt_pkg::TN_READ_HOLDING && l_register == $past(q_start) - 16'h2000)
		else $error("upper holding read mistranslated");
	AST_HOLD_LOWER: assert property (q_valid && !q_reply && q_func == mlt_pkg::FC_READ_HOLDING
		&& in_low |=> l_opcode == mlt_pkg::OP_PRIO_READ && l_status == 16'h0006)
		else $error("lower holding read mistranslated");
	AST_COIL_READ: assert property (q_valid && !q_reply && q_func == mlt_pkg::FC_READ_COILS
		|=> l_status[7:0] == 8'h03 && l_status[11:8] == $past(q_count[3:0])
		&& l_status[15:12] == 4'($past(q_start[3:0]) - 4'h1) && l_opcode == 8'h20)
		else $error("coil read status wrong");
	AST_DISC_READ: assert property (q_valid && !q_reply && q_func == mlt_pkg::FC_READ_DISCRETE
		|=> l_status[7:0] == 8'h05 && l_status[11:8] == $past(q_count[3:0]) && l_opcode == 8'h20)
		else $error("discrete read status wrong");
	AST_COIL_WRITE: assert property (q_valid && !q_reply && q_func == mlt_pkg::FC_WRITE_COIL
		|=> $onehot(l_mask) && l_transnum == 8'h05 && l_opcode == 8'h02)
		else $error("single coil write wrong");
	AST_MASK_NOT_FULL: assert property (l_valid && l_transnum == 8'h0F
		|-> l_mask != 16'hFFFF && l_mask != 16'h0000)
		else $error("coil mask invalid");
	AST_WRAP: assert property (l_valid && l_wrap |-> l_status == 16'hBAD5
		&& (l_opcode == 8'h22 || l_opcode == 8'h92))
		else $error("envelope status wrong");
	AST_REPLY: assert property (q_valid && q_reply |=> l_valid && l_opcode == 8'h92)
		else $error("reply not wrapped");
	AST_ADDR_ZERO: assert property (l_valid |-> l_addr_byte == 8'h00)
		else $error("address byte not zero");
	AST_HOST_BIAS: assert property (m_valid && host_mode
		|=> mb_valid && mb_register == 16'($past(m_remote) + $past(host_bias)))
		else $error("host register not biased");
	AST_GATE_NOBIAS: assert property (m_valid && !host_mode
		|=> mb_register == $past(m_remote) && mb_func != 8'h00)
		else $error("gate mode applied bias");
	AST_INBOUND_NOBIAS: assert property (q_valid && !q_reply && in_low
		&& q_func == mlt_pkg::FC_WRITE_REGS |=> l_register == $past(q_start))
		else $error("bias leaked inbound");

	// Main scenarios worth seeing.
	COV_UPPER: cover property (l_valid && l_status_sel);
	COV_WRAP: cover property (l_valid && l_wrap && l_opcode == 8'h22);
	COV_MASK: cover property (l_valid && l_transnum == 8'h0F);
	COV_HOST: cover property (mb_valid && state.bias != 16'h0000);

endmodule

/* File: tb/mlt_master_model.sv */
// Behavioural serial-side master that offers one query item per request.
module mlt_master_model (
	input  wire logic        clock,     // Bench clock.
	input  wire logic        rst,       // Synchronous reset, active high.
	input  wire logic        go,        // Bench asks for one item.
	input  wire logic        req_reply, // Item is a reply to a wrapped query.
	input  wire logic [7:0]  req_func,  // Function code to send.
	input  wire logic [15:0] req_start, // First register or coil.
	input  wire logic [15:0] req_count, // Register or coil count.
	output logic             q_valid,   // One-cycle offer pulse.
	output logic             q_reply,   // Reply flag with the pulse.
	output logic [7:0]       q_func,    // Function code with the pulse.
	output logic [15:0]      q_start,   // Start with the pulse.
	output logic [15:0]      q_count    // Count with the pulse.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Offers the item for exactly one cycle when asked.
	// Between items the fields flip every cycle, so a design that reads them late sees garbage.
	// codes chosen by bench
	always_ff @(posedge clock) begin
		if (rst) begin
			q_valid <= 1'b0;
			q_reply <= 1'b0;
			q_func  <= 8'h00;
			q_start <= 16'h0000;
			q_count <= 16'h0000;
		end else if (go) begin
			q_valid <= 1'b1;
			q_reply <= req_reply;
			q_func  <= req_func;
			q_start <= req_start;
			q_count <= req_count;
		end else begin
			q_valid <= 1'b0;
			q_reply <= ~q_reply;
			q_func  <= ~q_func;
			q_start <= ~q_start;
			q_count <= ~q_count;
		end
	end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the message translator.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 1'b0, rst = 1'b1, go = 1'b0, req_reply = 1'b0;
	logic [7:0] req_func = 8'h00;
	logic [15:0] req_start = 16'h0000, req_count = 16'h0000;
	logic q_valid, q_reply, l_valid, l_status_sel, l_wrap, mb_valid;
	logic [7:0] q_func, l_opcode, l_transnum, l_addr_byte, mb_func;
	logic [15:0] q_start, q_count, l_status, l_register, l_mask, mb_register;
	logic host_mode = 1'b0, m_valid = 1'b0, m_write = 1'b0;
	logic [7:0] host_read_fc = 8'h03, host_write_fc = 8'h10, m_transnum = 8'h00;
	logic [15:0] host_bias = 16'h0000, m_count = 16'h0000, m_remote = 16'h0000;
	int mismatches = 0, checks = 0, cycles = 0;

	// A 4 ns clock.
	always #2 clock = ~clock;

	mlt_master_model u_mlt_master_model (.clock(clock), .rst(rst), .go(go),
		.req_reply(req_reply), .req_func(req_func), .req_start(req_start),
		.req_count(req_count), .q_valid(q_valid), .q_reply(q_reply), .q_func(q_func),
		.q_start(q_start), .q_count(q_count));

	mlt_translator u_mlt_translator (.clock(clock), .rst(rst), .q_valid(q_valid),
		.q_reply(q_reply), .q_func(q_func), .q_start(q_start), .q_count(q_count),
		.l_valid(l_valid), .l_opcode(l_opcode), .l_status(l_status),
		.l_status_sel(l_status_sel), .l_transnum(l_transnum), .l_register(l_register),
		.l_mask(l_mask), .l_wrap(l_wrap), .l_addr_byte(l_addr_byte),
		.host_mode(host_mode), .host_read_fc(host_read_fc),
		.host_write_fc(host_write_fc), .host_bias(host_bias), .m_valid(m_valid),
		.m_write(m_write), .m_transnum(m_transnum), .m_count(m_count),
		.m_remote(m_remote), .mb_valid(mb_valid), .mb_func(mb_func),
		.mb_register(mb_register));

	// Compares one value; four-state so an unknown never matches.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Sends one inbound item and judges the legacy message; wrapped items skip the select, transaction number, register and mask checks.
	task automatic send_q(input logic [7:0] f, input logic [15:0] s, input logic [15:0] c,
		input logic r, input logic [7:0] op, input logic [15:0] st, input logic sel,
		input logic [7:0] tn, input logic [15:0] rg, input logic [15:0] mk, input logic wr);
		int n;
		@(posedge clock);
		go <= 1'b1;
		req_func <= f;
		req_start <= s;
		req_count <= c;
		req_reply <= r;
		@(posedge clock);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (l_valid !== 1'b1 && n < 4);
		chk(l_valid, 1'b1, "l_valid");
		chk(l_opcode, op, "l_opcode");
		chk(l_status, st, "l_status");
		chk(l_wrap, wr, "l_wrap");
		chk(l_addr_byte, 8'h00, "l_addr_byte");
		if (!wr) begin
			chk(l_status_sel, sel, "l_status_sel");
			chk(l_transnum, tn, "l_transnum");
			chk(l_register, rg, "l_register");
			chk(l_mask, mk, "l_mask");
		end
		// The answer comes exactly one edge after the item and stands one cycle.
		chk(16'(n), 16'h0001, "l_valid latency");
		@(posedge clock);
		#1;
		chk(l_valid, 1'b0, "l_valid pulse end");
	endtask

	// Sends one outbound request and judges the query; the answer comes one edge later.
	task automatic send_m(input logic hm, input logic w, input logic [7:0] tn,
		input logic [15:0] cnt, input logic [15:0] rem, input logic [15:0] bias,
		input logic [7:0] rfc, input logic [7:0] wfc, input logic [7:0] ef,
		input logic [15:0] er, input logic creg);
		@(posedge clock);
		host_mode <= hm;
		host_bias <= bias;
		host_read_fc <= rfc;
		host_write_fc <= wfc;
		m_valid <= 1'b1;
		m_write <= w;
		m_transnum <= tn;
		m_count <= cnt;
		m_remote <= rem;
		@(posedge clock);
		m_valid <= 1'b0;
		m_remote <= ~rem;
		m_count <= ~cnt;
		#1;
		chk(mb_valid, 1'b1, "mb_valid");
		chk(mb_func, ef, "mb_func");
		if (creg) chk(mb_register, er, "mb_register");
		// The outbound pulse stands for one cycle only.
		@(posedge clock);
		#1;
		chk(mb_valid, 1'b0, "mb_valid pulse end");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Cuts a hang short after far more cycles than the tests need.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			results();
		end
	end

	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk(l_valid, 1'b0, "reset l_valid");
		chk(mb_valid, 1'b0, "reset mb_valid");
		chk(l_opcode, 8'h00, "reset l_opcode");
		chk(mb_register, 16'h0000, "reset mb_register");
		send_q(8'h01, 16'h0014, 16'h0005, 0, 8'h20, 16'h3503, 0, 8'h00, 16'h0002, 16'h0000, 0);
		send_q(8'h02, 16'h0011, 16'h0012, 0, 8'h20, 16'h0205, 0, 8'h00, 16'h0002, 16'h0000, 0);
		send_q(8'h03, 16'h2000, 16'h0002, 0, 8'h20, 16'h0006, 0, 8'h00, 16'h2000, 16'h0000, 0);
		send_q(8'h03, 16'h2008, 16'h0001, 0, 8'h00, 16'h0000, 1, 8'h03, 16'h0008, 16'h0000, 0);
		send_q(8'h03, 16'h4000, 16'h0001, 0, 8'h00, 16'h0000, 1, 8'h03, 16'h2000, 16'h0000, 0);
		send_q(8'h04, 16'h0001, 16'h0003, 0, 8'h00, 16'h0009, 0, 8'h00, 16'h0001, 16'h0000, 0);
		send_q(8'h04, 16'h2001, 16'h0001, 0, 8'h22, 16'hBAD5, 0, 8'h00, 16'h0000, 16'h0000, 1);
		send_q(8'h05, 16'h0023, 16'h0001, 0, 8'h02, 16'h0000, 0, 8'h05, 16'h0003, 16'h0004, 0);
		send_q(8'h06, 16'h0064, 16'h0001, 0, 8'h1E, 16'h000D, 0, 8'h00, 16'h0064, 16'h0000, 0);
		send_q(8'h06, 16'h4000, 16'h0001, 0, 8'h02, 16'h0000, 1, 8'h06, 16'h2000, 16'h0000, 0);
		send_q(8'h0F, 16'h0011, 16'h0020, 0, 8'h1E, 16'h001F, 0, 8'h00, 16'h0002, 16'h0000, 0);
		send_q(8'h0F, 16'h0012, 16'h0003, 0, 8'h02, 16'h0000, 0, 8'h0F, 16'h0002, 16'h000E, 0);
		send_q(8'h0F, 16'h000F, 16'h0004, 0, 8'h22, 16'hBAD5, 0, 8'h00, 16'h0000, 16'h0000, 1);
		send_q(8'h10, 16'h0010, 16'h0004, 0, 8'h1E, 16'h0020, 0, 8'h00, 16'h0010, 16'h0000, 0);
		send_q(8'h10, 16'h2001, 16'h0002, 0, 8'h02, 16'h0000, 1, 8'h10, 16'h0001, 16'h0000, 0);
		send_q(8'h11, 16'h0001, 16'h0001, 0, 8'h22, 16'hBAD5, 0, 8'h00, 16'h0000, 16'h0000, 1);
		send_q(8'h11, 16'h0001, 16'h0001, 1, 8'h92, 16'hBAD5, 0, 8'h00, 16'h0000, 16'h0000, 1);
		send_m(1, 1, 8'h00, 16'h0004, 16'h1437, 16'h0FA0, 8'h03, 8'h10, 8'h10, 16'h23D7, 1);
		send_m(1, 0, 8'h00, 16'h0001, 16'h0079, 16'h0000, 8'h04, 8'h10, 8'h04, 16'h0079, 1);
		send_m(1, 0, 8'h00, 16'h0001, 16'h0002, 16'hFFFF, 8'h03, 8'h10, 8'h03, 16'h0001, 1);
		send_q(8'h03, 16'h0005, 16'h0001, 0, 8'h20, 16'h0006, 0, 8'h00, 16'h0005, 16'h0000, 0);
		send_m(0, 0, 8'h00, 16'h0001, 16'h0079, 16'h0FA0, 8'h04, 8'h06, 8'h03, 16'h0079, 1);
		send_m(0, 1, 8'h0F, 16'h0001, 16'h0002, 16'h0FA0, 8'h04, 8'h06, 8'h05, 16'h0002, 1);
		send_m(0, 1, 8'h0F, 16'h0003, 16'h0002, 16'h0000, 8'h04, 8'h06, 8'h0F, 16'h0002, 1);
		send_m(0, 1, 8'h01, 16'h0002, 16'h0030, 16'h0000, 8'h04, 8'h06, 8'h10, 16'h0030, 1);
		results();
	end
endmodule
